// ---- core/adcc_pkg.sv ----
// package for the conversion control block: register indices, field layout, timing
// assumes one 200 MHz clock and an AXI4-Lite register bus with byte address = 4 * index
package adcc_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] ADCC_IDX_PORT_A_PINS = 8'h05;
  localparam logic [7:0] ADCC_IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] ADCC_IDX_PERIPHERAL_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] ADCC_IDX_CONVERSION_RESULT = 8'h1e;
  localparam logic [7:0] ADCC_IDX_CONVERTER_CONTROL = 8'h1f;
  localparam logic [7:0] ADCC_IDX_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] ADCC_IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] ADCC_IDX_PIN_ANALOG_CONFIG = 8'h9f;
  // extra registers: compare unit mode and event status/enable/clear
  localparam logic [7:0] ADCC_IDX_COMPARE_UNIT_CONTROL = 8'h17;
  localparam logic [7:0] ADCC_IDX_EVENT_STATUS = 8'hc0;
  localparam logic [7:0] ADCC_IDX_EVENT_ENABLE = 8'hc1;
  localparam logic [7:0] ADCC_IDX_EVENT_CLEAR = 8'hc2;

  // reset values
  localparam logic [7:0] ADCC_RST_CONTROL = 8'h00;
  localparam logic [7:0] ADCC_RST_DIRECTION = 8'h3f;
  localparam logic [7:0] ADCC_RST_ZERO = 8'h00;

  // converter_control fields
  localparam int ADCC_CTL_CLKSEL_LSB = 6;
  localparam int ADCC_CTL_CHSEL_LSB = 3;
  localparam int ADCC_CTL_GO_BIT = 2;
  localparam int ADCC_CTL_POWER_BIT = 0;
  localparam logic [7:0] ADCC_CTL_WR_MASK = 8'hfd;
  // peripheral flag/enable and interrupt_control bits
  localparam int ADCC_PIR_DONE_BIT = 6;
  localparam int ADCC_INTERRUPT_CONTROL_GIE_BIT = 7;
  localparam int ADCC_INTERRUPT_CONTROL_PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam logic [7:0] ADCC_PIR_MASK = 8'h4f;
  localparam logic [7:0] ADCC_PORT_MASK = 8'h3f;
  localparam logic [7:0] ADCC_CFG_MASK = 8'h07;
  localparam logic [3:0] ADCC_CMP_SPECIAL_EVENT = 4'hb;
  // event status bits: 0 conversion done, 1 special trigger seen
  localparam int ADCC_EV_DONE = 0;
  localparam int ADCC_EV_TRIG = 1;
  localparam int ADCC_EV_NUM = 2;

  // clock select codes
  localparam logic [1:0] ADCC_CLK_OSC2 = 2'b00;
  localparam logic [1:0] ADCC_CLK_OSC8 = 2'b01;
  localparam logic [1:0] ADCC_CLK_OSC32 = 2'b10;
  localparam logic [1:0] ADCC_CLK_RC = 2'b11;

  // timing: oscillator period is one aclk; rc bit period typical 4 us
  localparam int ADCC_CLK_MHZ = 200;
  localparam int ADCC_RC_PERIOD_NS = 4000;
  localparam int ADCC_RC_CYCLES = ADCC_RC_PERIOD_NS * ADCC_CLK_MHZ / 1000;
  localparam logic [15:0] ADCC_RC_HALF = 16'(ADCC_RC_CYCLES / 2);
  localparam logic [15:0] ADCC_OSC2_HALF = 16'h0001;
  localparam logic [15:0] ADCC_OSC8_HALF = 16'h0004;
  localparam logic [15:0] ADCC_OSC32_HALF = 16'h0010;
  // a conversion lasts 19 half bit periods (9.5 bit periods)
  localparam logic [4:0] ADCC_CONV_HALVES = 5'd19;
  localparam int ADCC_BITS = 8;

  // axi response codes
  localparam logic [1:0] ADCC_RESP_OKAY = 2'b00;
  localparam logic [1:0] ADCC_RESP_SLVERR = 2'b10;

  // analog front end request to the successive approximation core
  typedef struct packed {
    logic start;
    logic [1:0] clock_select;
    logic [2:0] channel;
  } adcc_conv_req_type;

  // answer from the core
  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] result;
  } adcc_conv_rsp_type;

endpackage

// ---- core/adcc_tick_gen.sv ----
// half bit period tick generator for the conversion clock
// assumes aclk is the oscillator; the rc source is modelled by a fixed divide
module adcc_tick_gen
  import adcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [1:0] clock_select,
  output logic half_tick
);

  // all state in one struct
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } adcc_tick_state_type;

  adcc_tick_state_type state;
  adcc_tick_state_type next_state;
  logic [15:0] half_len; // cycles per half bit period

  // period selection from the clock select code
  always_comb begin
    unique case (clock_select)
      ADCC_CLK_OSC2: half_len = ADCC_OSC2_HALF;
      ADCC_CLK_OSC8: half_len = ADCC_OSC8_HALF;
      ADCC_CLK_OSC32: half_len = ADCC_OSC32_HALF;
      ADCC_CLK_RC: half_len = ADCC_RC_HALF;
    endcase
  end

  // counter restarts whenever the converter is idle, so phase starts at go
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (!run) begin
      next_state.count = 16'h0000;
    end else if (state.count == half_len - 16'h0001) begin
      next_state.count = 16'h0000;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 16'h0001;
    end
  end

  // register the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign half_tick = state.tick;

endmodule

// ---- core/adcc_sar.sv ----
// successive approximation sequencer: one trial per bit period
// assumes the comparator input is a synchronous digital stand-in for the analog level
module adcc_sar
  import adcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic half_tick,
  input wire adcc_conv_req_type req,
  input wire logic [7:0] sample_level,
  output adcc_conv_rsp_type rsp
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] halves;
    logic [7:0] trial;
    logic [7:0] result;
  } adcc_sar_state_type;

  adcc_sar_state_type state;
  adcc_sar_state_type next_state;

  // binary search; result loads after 19 half periods
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    if (!state.busy) begin
      if (req.start) begin
        next_state.busy = 1'b1;
        next_state.halves = 5'd0;
        next_state.trial = 8'h00;
      end
    end else if (half_tick) begin
      next_state.halves = state.halves + 5'd1;
      // odd half ticks below 16 resolve one bit, msb first
      if (state.halves[0] && state.halves < 5'd16) begin
        next_state.trial[3'(7 - state.halves[4:1])] = 1'b1;
        if (sample_level < (state.trial | (8'h80 >> state.halves[4:1]))) begin
          next_state.trial[3'(7 - state.halves[4:1])] = 1'b0;
        end
      end
      if (state.halves == ADCC_CONV_HALVES - 5'd1) begin
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
        next_state.result = state.trial;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rsp.busy = state.busy;
  assign rsp.done = state.done;
  assign rsp.result = state.result;

endmodule

// ---- core/adcc_top.sv ----
// conversion control block: registers over axi4-lite, trigger, port mux, interrupt
// assumes all inputs synchronous to aclk; analog inputs arrive as 8-bit levels
//
// Functional notes
// - conversion takes nine and a half bit periods
// - clock select chooses 2, 8, 32 osc or rc
// - rc source gives about four microsecond period
// - output-direction pin converts its driven level
// - conversion ignores the analog config bits
// - analog-configured pins read zero from port
// - digital input pins still convert their level
// - special event with power on starts conversion
// - special event clears the sixteen bit timer
// - powered off ignores trigger, timer still clears
// - go starts conversion, reads one while busy unless the start meets completion in the same cycle
// - completion loads result, clears go, flags done
// - channel select codes pick inputs zero to four
module adcc_top
  import adcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [39:0] analog_input_pins, // five 8-bit levels
  input wire logic [5:0] port_a_in, // digital pin levels
  input wire logic compare_match, // one-cycle compare match pulse
  output logic [5:0] port_a_out, // pin output data
  output logic [5:0] port_a_oe, // high while driving
  output logic timer_clear, // clears the sixteen bit timer
  output logic irq // level interrupt
);

  // all register state
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic [7:0] control; // converter_control
    logic [7:0] interrupt_control; // interrupt_control
    logic [7:0] pir; // peripheral_irq_flags
    logic [7:0] pie; // peripheral_irq_enables
    logic [7:0] result; // conversion_result
    logic [7:0] direction; // port_a_direction
    logic [5:0] oe; // pin drivers, high = driven, kept in step with direction
    logic [7:0] port_latch; // port output latch
    logic [7:0] analog_cfg; // pin_analog_config
    logic [3:0] compare_mode; // compare_mode_field
    logic [ADCC_EV_NUM-1:0] ev_status;
    logic [ADCC_EV_NUM-1:0] ev_enable;
    logic start;
    logic timer_clear;
    logic irq;
  } adcc_top_state_type;

  adcc_top_state_type state;
  adcc_top_state_type next_state;
  adcc_conv_req_type conv_req;
  adcc_conv_rsp_type conv_rsp;
  logic half_tick;
  logic [7:0] sample_level; // level seen by the comparator
  logic [5:0] analog_mask; // pins configured as analog
  logic [7:0] port_read;
  logic [4:0][7:0] levels;
  logic [7:0] wr_byte;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic special_event;
  logic wr_fire;
  logic rd_fire;
  logic [ADCC_EV_NUM-1:0] ev_set;

  // bit period source
  adcc_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(conv_rsp.busy),
    .clock_select(state.control[ADCC_CTL_CLKSEL_LSB +: 2]),
    .half_tick(half_tick)
  );

  // successive approximation core
  adcc_sar u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .half_tick(half_tick),
    .req(conv_req),
    .sample_level(sample_level),
    .rsp(conv_rsp)
  );

  assign conv_req.start = state.start;
  assign conv_req.clock_select = state.control[ADCC_CTL_CLKSEL_LSB +: 2];
  assign conv_req.channel = state.control[ADCC_CTL_CHSEL_LSB +: 3];
  assign levels = analog_input_pins;

  // analog pin map per config code: ra0,ra1 analog below 11x, ra3 only for even codes below 11x; ra2,ra5 below 100
  always_comb begin
    analog_mask = 6'b000000;
    if (state.analog_cfg[2:1] != 2'b11) begin
      analog_mask[0] = 1'b1;
      analog_mask[1] = 1'b1;
      analog_mask[3] = !state.analog_cfg[0];
      if (!state.analog_cfg[2]) begin
        analog_mask[2] = 1'b1;
        analog_mask[5] = 1'b1;
      end
    end
  end

  // input selection; an output pin presents its driven level, a digital
  // pin its own level, so direction and config never block the sample
  always_comb begin
    unique case (state.control[ADCC_CTL_CHSEL_LSB +: 3])
      3'b000: sample_level = (!state.direction[0]) ? {8{state.port_latch[0]}} : levels[0];
      3'b001: sample_level = (!state.direction[1]) ? {8{state.port_latch[1]}} : levels[1];
      3'b010: sample_level = (!state.direction[2]) ? {8{state.port_latch[2]}} : levels[2];
      3'b011: sample_level = (!state.direction[3]) ? {8{state.port_latch[3]}} : levels[3];
      3'b100: sample_level = (!state.direction[5]) ? {8{state.port_latch[5]}} : levels[4];
      default: sample_level = 8'h00;
    endcase
  end

  // analog-configured pins read back as zero
  assign port_read = {2'b00, port_a_in & ~analog_mask};

  // write byte from the low lane
  assign wr_byte = state.wdata[7:0];
  assign wr_idx = state.awaddr[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_fire = state.aw_held && state.w_held && !state.bvalid;
  assign rd_fire = s_axi_arvalid && state.arready;
  // special event only in the trigger compare mode
  assign special_event = compare_match && (state.compare_mode == ADCC_CMP_SPECIAL_EVENT);
  assign ev_set = {special_event, conv_rsp.done};

  // main next-state logic
  always_comb begin
    next_state = state;
    next_state.start = 1'b0;
    // special event clears the timer regardless of power
    next_state.timer_clear = special_event;

    // write address and data taken in either order
    if (s_axi_awvalid && state.awready) begin
      next_state.awaddr = s_axi_awaddr;
      next_state.aw_held = 1'b1;
      next_state.awready = 1'b0;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.wdata = s_axi_wdata;
      next_state.wstrb = s_axi_wstrb;
      next_state.w_held = 1'b1;
      next_state.wready = 1'b0;
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready = 1'b1;
    end

    // register writes; only byte lane 0 carries data
    if (wr_fire) begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = ADCC_RESP_OKAY;
      unique case (wr_idx)
        ADCC_IDX_CONVERTER_CONTROL: if (state.wstrb[0]) begin
          next_state.control = (wr_byte & ADCC_CTL_WR_MASK)
                             | (state.control & ~ADCC_CTL_WR_MASK);
          // go never lands from the write itself, else it would stick with no conversion
          next_state.control[ADCC_CTL_GO_BIT] = state.control[ADCC_CTL_GO_BIT];
          // go while powered starts a conversion; go is kept by hardware
          if (wr_byte[ADCC_CTL_GO_BIT] && state.control[ADCC_CTL_POWER_BIT]
              && wr_byte[ADCC_CTL_POWER_BIT] && !conv_rsp.busy) begin
            next_state.start = 1'b1;
            next_state.control[ADCC_CTL_GO_BIT] = 1'b1;
          end
        end
        ADCC_IDX_INTERRUPT_CONTROL: if (state.wstrb[0]) next_state.interrupt_control = wr_byte;
        ADCC_IDX_PERIPHERAL_IRQ_FLAGS: if (state.wstrb[0]) begin
          next_state.pir = wr_byte & ADCC_PIR_MASK;
        end
        ADCC_IDX_PERIPHERAL_IRQ_ENABLES: if (state.wstrb[0]) begin
          next_state.pie = wr_byte & ADCC_PIR_MASK;
        end
        ADCC_IDX_PORT_A_DIRECTION: if (state.wstrb[0]) begin
          next_state.direction = wr_byte & ADCC_PORT_MASK;
        end
        ADCC_IDX_PORT_A_PINS: if (state.wstrb[0]) begin
          next_state.port_latch = wr_byte & ADCC_PORT_MASK;
        end
        ADCC_IDX_PIN_ANALOG_CONFIG: if (state.wstrb[0]) begin
          next_state.analog_cfg = wr_byte & ADCC_CFG_MASK;
        end
        ADCC_IDX_COMPARE_UNIT_CONTROL: if (state.wstrb[0]) begin
          next_state.compare_mode = wr_byte[3:0];
        end
        ADCC_IDX_EVENT_ENABLE: if (state.wstrb[0]) begin
          next_state.ev_enable = wr_byte[ADCC_EV_NUM-1:0];
        end
        ADCC_IDX_EVENT_CLEAR: if (state.wstrb[0]) begin
          next_state.ev_status = state.ev_status & ~wr_byte[ADCC_EV_NUM-1:0];
        end
        ADCC_IDX_CONVERSION_RESULT: ; // read only, write ignored
        default: next_state.bresp = ADCC_RESP_SLVERR;
      endcase
    end

    // powering down drops the go request too, once no conversion is busy
    if (!next_state.control[ADCC_CTL_POWER_BIT] && !conv_rsp.busy) begin
      next_state.control[ADCC_CTL_GO_BIT] = 1'b0;
    end

    // trigger sets go only while powered
    if (special_event && state.control[ADCC_CTL_POWER_BIT] && !conv_rsp.busy) begin
      next_state.start = 1'b1;
      next_state.control[ADCC_CTL_GO_BIT] = 1'b1;
    end

    // completion: result, go cleared, done flag set; set beats a clear
    if (conv_rsp.done) begin
      next_state.result = conv_rsp.result;
      next_state.control[ADCC_CTL_GO_BIT] = 1'b0;
      next_state.pir[ADCC_PIR_DONE_BIT] = 1'b1;
    end
    // sticky event status, set wins over clear
    next_state.ev_status = next_state.ev_status | ev_set;

    // reads answer one cycle after the address is taken
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
      next_state.arready = 1'b1;
    end
    if (rd_fire) begin
      next_state.arready = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rresp = ADCC_RESP_OKAY;
      next_state.rdata = 32'h00000000;
      unique case (rd_idx)
        ADCC_IDX_CONVERTER_CONTROL: next_state.rdata[7:0] = state.control;
        ADCC_IDX_INTERRUPT_CONTROL: next_state.rdata[7:0] = state.interrupt_control;
        ADCC_IDX_PERIPHERAL_IRQ_FLAGS: next_state.rdata[7:0] = state.pir;
        ADCC_IDX_PERIPHERAL_IRQ_ENABLES: next_state.rdata[7:0] = state.pie;
        ADCC_IDX_CONVERSION_RESULT: next_state.rdata[7:0] = state.result;
        ADCC_IDX_PORT_A_DIRECTION: next_state.rdata[7:0] = state.direction;
        ADCC_IDX_PORT_A_PINS: next_state.rdata[7:0] = port_read;
        ADCC_IDX_PIN_ANALOG_CONFIG: next_state.rdata[7:0] = state.analog_cfg;
        ADCC_IDX_COMPARE_UNIT_CONTROL: next_state.rdata[3:0] = state.compare_mode;
        ADCC_IDX_EVENT_STATUS: next_state.rdata[ADCC_EV_NUM-1:0] = state.ev_status;
        ADCC_IDX_EVENT_ENABLE: next_state.rdata[ADCC_EV_NUM-1:0] = state.ev_enable;
        ADCC_IDX_EVENT_CLEAR: ; // write only, reads zero
        default: next_state.rresp = ADCC_RESP_SLVERR;
      endcase
    end

    // pin drivers follow the direction register in the same edge
    next_state.oe = ~next_state.direction[5:0];

    // interrupt: done flag with its enable through both global gates, or event path
    next_state.irq = (next_state.pir[ADCC_PIR_DONE_BIT] && next_state.pie[ADCC_PIR_DONE_BIT]
                      && next_state.interrupt_control[ADCC_INTERRUPT_CONTROL_GIE_BIT]
                      && next_state.interrupt_control[ADCC_INTERRUPT_CONTROL_PERIPHERAL_IRQ_ENABLE_BIT])
                     || (|(next_state.ev_status & next_state.ev_enable));
  end

  // register everything; result is left as zero at reset for determinism
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.awready <= 1'b1;
      state.wready <= 1'b1;
      state.arready <= 1'b1;
      state.control <= ADCC_RST_CONTROL;
      state.direction <= ADCC_RST_DIRECTION;
      state.pir <= ADCC_RST_ZERO;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rresp = state.rresp;
  assign s_axi_rdata = state.rdata;
  assign port_a_out = state.port_latch[5:0];
  assign port_a_oe = state.oe;
  assign timer_clear = state.timer_clear;
  assign irq = state.irq;

endmodule

// ---- dv/adcc_top_assertions.sv ----
// port checker for the conversion control block
// assumes binding to adcc_top; sees only its ports
module adcc_top_assertions
  import adcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic compare_match,
  input wire logic timer_clear,
  input wire logic [5:0] port_a_oe
);
  // one domain, so one clock and reset for all
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both halves held one cycle, then the answer is registered
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
  a_b_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("no read answer");
  // registers are one byte wide, upper bits read zero
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_trig_clear: assert property (timer_clear |-> $past(compare_match))
    else $error("timer clear without match");
  a_clear_pulse: assert property (timer_clear |=> !timer_clear)
    else $error("timer clear longer than one cycle");
  // reset leaves every pin an input
  a_oe_reset: assert property (disable iff (1'b0) !aresetn |=> port_a_oe == 6'h00)
    else $error("pin driven after reset");
endmodule

bind adcc_top adcc_top_assertions u_chk (.*);

// ---- dv/tb.sv ----
// testbench: registers over axi4-lite, pin levels and compare match
// assumes adcc_top and its package; the bench drives all ports itself
module tb
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] CTL = ADCC_IDX_CONVERTER_CONTROL;
  localparam logic [7:0] FLG = ADCC_IDX_PERIPHERAL_IRQ_FLAGS;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'h1;
  // ready lines held high: the bench never stalls answers
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, compare_match = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic timer_clear, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rv;
  logic [5:0] port_a_out, port_a_oe;
  // channel levels 3c 5a a5 c3 69, digital pins all high
  logic [39:0] analog_input_pins = 40'h69c3a55a3c;
  logic [5:0] port_a_in = 6'h3f;
  logic [15:0] hv [4] = '{ADCC_OSC2_HALF, ADCC_OSC8_HALF, ADCC_OSC32_HALF, ADCC_RC_HALF};
  logic [7:0] pc [4] = '{8'h00, 8'h01, 8'h04, 8'h06};
  logic [7:0] pe [4] = '{8'h10, 8'h18, 8'h34, 8'h3f};
  logic ie = 1'b0;
  int err_total = 0, n_checks = 0, cyc = 0, n;

  adcc_top uut (.*);

  // 200 MHz clock
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  task summarize;
    $display("mismatches %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // a wait that runs out ends the run
  task tmo;
    chk("timeout", 32'h1, 32'h0);
    summarize();
  endtask
  // write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] i, input logic [7:0] d);
    int k;
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 50) tmo();
    resp = s_axi_bresp;
  endtask
  task rd(input logic [7:0] i);
    int k;
    s_axi_araddr <= {22'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 50) tmo();
    rv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task rc(input string nm, input logic [7:0] i, input logic [31:0] e);
    rd(i);
    chk(nm, rv, e);
  endtask
  // poll go until clear, then result, flag and interrupt
  task wait_done(input string nm, input logic [7:0] exp);
    int k;
    for (k = 0; k < 4000; k++) begin
      rd(CTL);
      if (rv[ADCC_CTL_GO_BIT] === 1'b0) break;
    end
    if (k == 4000) tmo();
    rc(nm, ADCC_IDX_CONVERSION_RESULT, {24'h0, exp});
    rd(FLG);
    chk("done_flag", rv[ADCC_PIR_DONE_BIT], 32'h1);
    chk("irq", irq, ie);
    wr(FLG, 8'h00); // clearing and polling leave the gap before the next start
  endtask
  // software start; duration bounded around 19 half bit periods
  task conv(input string nm, input logic [7:0] ctl, input logic [7:0] exp);
    int t0;
    logic [15:0] h;
    h = hv[ctl[7:6]];
    wr(CTL, ctl); // power already on before go
    t0 = cyc;
    rc("go_busy", CTL, {24'h0, ctl});
    wait_done(nm, exp);
    chk("duration", (cyc - t0 >= 19 * h - 4) && (cyc - t0 <= 19 * h + 16), 32'h1);
  endtask
  task pulse;
    compare_match <= 1'b1;
    @(posedge aclk);
    compare_match <= 1'b0;
    @(posedge aclk);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc("ctl_rst", CTL, 32'h0);
    rc("dir_rst", ADCC_IDX_PORT_A_DIRECTION, 32'h3f);
    rc("cfg_rst", ADCC_IDX_PIN_ANALOG_CONFIG, 32'h0);
    rc("flg_rst", FLG, 32'h0);
    rc("ie_rst", ADCC_IDX_PERIPHERAL_IRQ_ENABLES, 32'h0);
    rd(8'h40);
    chk("unmapped", resp, ADCC_RESP_SLVERR);
    wr(8'h40, 8'h00);
    chk("wr_unmapped", resp, ADCC_RESP_SLVERR);
    wr(ADCC_IDX_CONVERSION_RESULT, 8'hff);
    chk("wr_ro", resp, ADCC_RESP_OKAY);
    rc("ro_kept", ADCC_IDX_CONVERSION_RESULT, 32'h0);
    // go together with power-up must not start
    wr(CTL, 8'h05);
    rc("go_at_power", CTL, 32'h1);
    wr(ADCC_IDX_PERIPHERAL_IRQ_ENABLES, 8'h40);
    wr(ADCC_IDX_INTERRUPT_CONTROL, 8'hc0);
    ie = 1'b1;
    // every channel and clock code; the level stand-in needs no minimum bit period
    for (n = 0; n < 5; n++)
      conv("result", {n[1:0], n[2:0], 3'b101}, analog_input_pins[8 * n +: 8]);
    repeat (2) @(posedge aclk);
    chk("irq_clear", irq, 32'h0);
    wr(ADCC_IDX_INTERRUPT_CONTROL, 8'h00);
    ie = 1'b0;
    for (n = 0; n < 4; n++) begin
      wr(ADCC_IDX_PIN_ANALOG_CONFIG, pc[n]);
      rc("port_read", ADCC_IDX_PORT_A_PINS, {24'h0, pe[n]});
    end
    conv("digital_pin", 8'h0d, 8'h5a);
    wr(ADCC_IDX_PORT_A_PINS, 8'h01);
    wr(ADCC_IDX_PORT_A_DIRECTION, 8'h3e);
    chk("oe", port_a_oe, 32'h1);
    chk("latch", port_a_out[0], 32'h1);
    conv("driven_pin", 8'h05, 8'hff);
    wr(ADCC_IDX_PORT_A_DIRECTION, 8'h3f);
    // compare trigger: wrong mode, right mode, converter off
    pulse();
    chk("no_clear", timer_clear, 32'h0);
    rc("no_start", CTL, 32'h1);
    wr(ADCC_IDX_COMPARE_UNIT_CONTROL, {4'h0, ADCC_CMP_SPECIAL_EVENT}); // channel set first
    pulse();
    chk("tmr_clr", timer_clear, 32'h1);
    rc("trig_go", CTL, 32'h5);
    wait_done("trig_result", 8'h3c);
    wr(CTL, 8'h00);
    pulse();
    chk("off_clr", timer_clear, 32'h1);
    rc("off_go", CTL, 32'h0);
    rc("off_flag", FLG, 32'h0);
    // event status, enable and clear
    rc("ev_status", ADCC_IDX_EVENT_STATUS, 32'h3);
    wr(ADCC_IDX_EVENT_ENABLE, 8'h03);
    repeat (2) @(posedge aclk);
    chk("ev_irq", irq, 32'h1);
    wr(ADCC_IDX_EVENT_CLEAR, 8'h03);
    repeat (2) @(posedge aclk);
    chk("ev_irq_off", irq, 32'h0);
    rc("ev_cleared", ADCC_IDX_EVENT_STATUS, 32'h0);
    rc("ev_clr_read", ADCC_IDX_EVENT_CLEAR, 32'h0);
    summarize();
  end
endmodule
